// >>> src/plts_pkg.sv
// Package for the two-channel position latch: command codes, error codes,
// selector encodings, status bit positions and the frame carrier structs.
// Assumes command frames are already parsed into fields by the frame logic.
package plts_pkg;

  localparam logic [3:0] PLTS_TYPE_LATCH_HI = 4'h5;
  localparam int PLTS_ENA_A_BIT = 0;
  localparam int PLTS_ENA_B_BIT = 1;
  localparam int PLTS_DIS_A_BIT = 2;
  localparam int PLTS_DIS_B_BIT = 3;
  localparam logic [7:0] PLTS_TYPE_MONITOR_ONLY = 8'h50;

  localparam logic [15:0] PLTS_ERR_NONE = 16'h0000;
  localparam logic [15:0] PLTS_ERR_RESERVED = 16'h0032;
  localparam logic [15:0] PLTS_ERR_ABS_SCALE = 16'h005a;

  localparam logic [3:0] PLTS_SEL_ZPULSE = 4'h0;
  localparam logic [3:0] PLTS_SEL_RISE_A = 4'h1;
  localparam logic [3:0] PLTS_SEL_RISE_C = 4'h3;
  localparam logic [3:0] PLTS_SEL_FALL_A = 4'h9;
  localparam logic [3:0] PLTS_SEL_FALL_C = 4'hb;

  localparam logic [7:0] PLTS_MON_POS_A = 8'h09;
  localparam logic [7:0] PLTS_MON_POS_B = 8'h0a;
  localparam logic [31:0] PLTS_MON_NONE = 32'h0000_0000;

  localparam int PLTS_ST_DONE_A = 0;
  localparam int PLTS_ST_DONE_B = 1;
  localparam int PLTS_ST_BUSY = 4;
  localparam int PLTS_ST_WARN = 6;
  localparam int PLTS_ST_ERR = 7;

  // One received command frame, already split into fields
  typedef struct packed {
    logic isLatch;
    logic isMonitor;
    logic isPosInit;
    logic [7:0] typeCode;
    logic [7:0] trigSel;
    logic [7:0] monitorSel;
  } plts_cmd_t;

  // Response fields owned by this block
  typedef struct packed {
    logic [15:0] cmdError;
    logic [7:0] typeCodeEcho;
    logic [7:0] status;
    logic [7:0] trigSelEcho;
    logic [7:0] monitorSelEcho;
    logic [31:0] monitorData;
  } plts_rsp_t;

  // Qualified trigger events, one cycle each
  typedef struct packed {
    logic zEdge;
    logic [2:0] rise;
    logic [2:0] fall;
  } plts_trig_t;

  function automatic logic plts_sel_reserved(input logic [3:0] sel);
    return !(sel == PLTS_SEL_ZPULSE
             || (sel >= PLTS_SEL_RISE_A && sel <= PLTS_SEL_RISE_C)
             || (sel >= PLTS_SEL_FALL_A && sel <= PLTS_SEL_FALL_C));
  endfunction

endpackage

// >>> src/plts_capture_ch.sv
// One latch channel: arm/cancel state, trigger selection and capture.
// Assumes trigger events are synchronised single-cycle pulses on clk.
`timescale 1ns/1ps
module plts_capture_ch (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Control
  input wire logic arm,
  input wire logic cancel,
  input wire logic [3:0] trigSel,
  input wire plts_pkg::plts_trig_t trig,
  input wire logic [31:0] actualPos,
  // State
  output logic armed,
  output logic done,
  output logic [31:0] capPos
);
  import plts_pkg::*;

  logic armed_r, armed_nxt;
  logic done_r, done_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic [31:0] pos_r, pos_nxt;
  logic hit;

  always_comb begin
    hit = 1'b0;
    if (sel_r == PLTS_SEL_ZPULSE) begin
      hit = trig.zEdge;
    end else if (sel_r >= PLTS_SEL_RISE_A && sel_r <= PLTS_SEL_RISE_C) begin
      hit = trig.rise[2'(sel_r - PLTS_SEL_RISE_A)];
    end else if (sel_r >= PLTS_SEL_FALL_A && sel_r <= PLTS_SEL_FALL_C) begin
      hit = trig.fall[2'(sel_r - PLTS_SEL_FALL_A)];
    end
    hit = hit && armed_r;
  end

  always_comb begin
    armed_nxt = armed_r;
    done_nxt = done_r;
    sel_nxt = sel_r;
    pos_nxt = pos_r;
    if (hit) begin
      armed_nxt = 1'b0;
      pos_nxt = actualPos;
    end
    if (arm) begin
      armed_nxt = 1'b1;
      sel_nxt = trigSel;
    end
    // Cancel beats a start in the same frame
    if (cancel) begin
      armed_nxt = 1'b0;
    end
    // Capture flag set wins over the clear from a restart
    done_nxt = hit ? 1'b1 : (arm ? 1'b0 : done_r);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      armed_r <= 1'b0;
      done_r <= 1'b0;
      sel_r <= PLTS_SEL_ZPULSE;
      pos_r <= PLTS_MON_NONE;
    end else if (ce) begin
      armed_r <= armed_nxt;
      done_r <= done_nxt;
      sel_r <= sel_nxt;
      pos_r <= pos_nxt;
    end
  end

  assign armed = armed_r;
  assign done = done_r;
  assign capPos = pos_r;

  capture_pos_a: assert property (@(posedge clk) disable iff (!reset_n)
    ce && hit |=> done_r && pos_r == $past(actualPos))
    else $error("capture did not store position");
  cover_capture_c: cover property (@(posedge clk) disable iff (!reset_n)
    ce && hit);
endmodule

// >>> src/plts_latch.sv
// Two-channel position latch behind the cyclic command/response frames.
// Assumes a frame parser presents each command for one cycle on cmdValid;
// trigger and index pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
// Summary of operation
// - Selector 0 latches on the index pulse, taken from the scale when full-closed is active.
// - Selector 0 with a serial absolute scale fitted is rejected with error 005Ah.
// - Selectors 1, 2, 3 capture on the rising edge of trigger input a, b, c.
// - Selectors 9, 10, 11 capture on the falling edge of trigger input a, b, c.
// - Selectors 4 to 8 and 12 to 15 are rejected with error 0032h.
// - Response byte 9 carries channel a's done flag in bit 0 and channel b's in bit 1.
// - Type code 50h reports the done flags and leaves every latch state untouched.
// - The monitor selector in byte 11 picks what the four-byte monitor data returns.
// - Monitor selector 09h returns the position captured by channel a.
// - Monitor selector 0Ah returns the position captured by channel b.
// - Latch type code bits start a, start b, cancel a, cancel b; combined codes act on both.
// - The busy flag stays 0 while latching so other commands may run.
// - A command that initialises position information cancels any armed latch.
module plts_latch (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // Command frame
  input wire logic cmdValid,
  input wire plts_pkg::plts_cmd_t cmd,
  // Response frame
  output logic rspValid,
  output plts_pkg::plts_rsp_t rsp,
  // Trigger and index pins
  input wire logic ext_trigger_a,
  input wire logic ext_trigger_b,
  input wire logic ext_trigger_c,
  input wire logic encoderIndex,
  input wire logic scaleIndex,
  // Drive state
  input wire logic fullClosed,
  input wire logic serialAbsScale,
  input wire logic warning_flag,
  input wire logic [31:0] actualPos,
  // Latch state
  output logic armedA,
  output logic armedB,
  output logic capture_done_ch_a,
  output logic capture_done_ch_b
);
  import plts_pkg::*;

  localparam int NPIN = 5;

  logic [NPIN-1:0] pinMeta_r, pinMeta_nxt;
  logic [NPIN-1:0] pinSync_r, pinSync_nxt;
  logic [NPIN-1:0] pinPrev_r, pinPrev_nxt;
  logic [NPIN-1:0] pinRise, pinFall;
  plts_trig_t trig;

  // Two stages before any logic looks at the pins
  always_comb begin
    pinMeta_nxt = {scaleIndex, encoderIndex, ext_trigger_c, ext_trigger_b, ext_trigger_a};
    pinSync_nxt = pinMeta_r;
    pinPrev_nxt = pinSync_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      pinPrev_r <= '0;
    end else if (ce) begin
      pinMeta_r <= pinMeta_nxt;
      pinSync_r <= pinSync_nxt;
      pinPrev_r <= pinPrev_nxt;
    end
  end

  always_comb begin
    pinRise = pinSync_r & ~pinPrev_r;
    pinFall = ~pinSync_r & pinPrev_r;
    trig.rise = pinRise[2:0];
    trig.fall = pinFall[2:0];
    trig.zEdge = fullClosed ? pinRise[4] : pinRise[3];
  end

  // Command decode
  logic latchCmd;
  logic [3:0] selA, selB;
  logic startA, startB, stopA, stopB;
  logic [15:0] errCode;

  always_comb begin
    latchCmd = cmdValid && cmd.isLatch && cmd.typeCode[7:4] == PLTS_TYPE_LATCH_HI;
    selA = cmd.trigSel[3:0];
    selB = cmd.trigSel[7:4];
    errCode = PLTS_ERR_NONE;
    if (latchCmd) begin
      if ((cmd.typeCode[PLTS_ENA_A_BIT] && plts_sel_reserved(selA))
          || (cmd.typeCode[PLTS_ENA_B_BIT] && plts_sel_reserved(selB))) begin
        errCode = PLTS_ERR_RESERVED;
      // No index pulse on serial scale
      end else if (serialAbsScale
                   && ((cmd.typeCode[PLTS_ENA_A_BIT] && selA == PLTS_SEL_ZPULSE)
                       || (cmd.typeCode[PLTS_ENA_B_BIT] && selB == PLTS_SEL_ZPULSE))) begin
        errCode = PLTS_ERR_ABS_SCALE;
      end
    end
    startA = latchCmd && errCode == PLTS_ERR_NONE && cmd.typeCode[PLTS_ENA_A_BIT];
    startB = latchCmd && errCode == PLTS_ERR_NONE && cmd.typeCode[PLTS_ENA_B_BIT];
    stopA = latchCmd && errCode == PLTS_ERR_NONE && cmd.typeCode[PLTS_DIS_A_BIT];
    stopB = latchCmd && errCode == PLTS_ERR_NONE && cmd.typeCode[PLTS_DIS_B_BIT];
    if (cmdValid && cmd.isPosInit) begin
      stopA = 1'b1;
      stopB = 1'b1;
    end
  end

  logic [31:0] capPosA, capPosB;

  plts_capture_ch chanA (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .arm(startA),
    .cancel(stopA),
    .trigSel(selA),
    .trig(trig),
    .actualPos(actualPos),
    .armed(armedA),
    .done(capture_done_ch_a),
    .capPos(capPosA)
  );

  plts_capture_ch chanB (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .arm(startB),
    .cancel(stopB),
    .trigSel(selB),
    .trig(trig),
    .actualPos(actualPos),
    .armed(armedB),
    .done(capture_done_ch_b),
    .capPos(capPosB)
  );

  // Response frame
  logic rspValid_r, rspValid_nxt;
  plts_rsp_t rsp_r, rsp_nxt;

  always_comb begin
    rspValid_nxt = cmdValid;
    rsp_nxt = rsp_r;
    if (cmdValid) begin
      rsp_nxt.cmdError = errCode;
      rsp_nxt.typeCodeEcho = cmd.typeCode;
      rsp_nxt.status = '0;
      rsp_nxt.status[PLTS_ST_DONE_A] = capture_done_ch_a;
      rsp_nxt.status[PLTS_ST_DONE_B] = capture_done_ch_b;
      rsp_nxt.status[PLTS_ST_BUSY] = 1'b0;
      rsp_nxt.status[PLTS_ST_WARN] = warning_flag;
      rsp_nxt.status[PLTS_ST_ERR] = errCode != PLTS_ERR_NONE;
      rsp_nxt.trigSelEcho = cmd.trigSel;
      rsp_nxt.monitorSelEcho = cmd.monitorSel;
      if (cmd.isMonitor) begin
        case (cmd.monitorSel)
          PLTS_MON_POS_A: rsp_nxt.monitorData = capPosA;
          PLTS_MON_POS_B: rsp_nxt.monitorData = capPosB;
          default: rsp_nxt.monitorData = PLTS_MON_NONE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rspValid_r <= 1'b0;
      rsp_r <= '0;
    end else if (ce) begin
      rspValid_r <= rspValid_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign rspValid = rspValid_r;
  assign rsp = rsp_r;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);

  busy_low_a: assert property (!rsp_r.status[PLTS_ST_BUSY])
    else $error("busy flag set");
  reserved_err_a: assert property (
    ce && latchCmd && cmd.typeCode[PLTS_ENA_A_BIT] && plts_sel_reserved(selA)
    |=> rspValid_r && rsp_r.cmdError == PLTS_ERR_RESERVED && !$rose(armedA))
    else $error("reserved selector not refused");
  abs_scale_err_a: assert property (
    ce && latchCmd && serialAbsScale && cmd.typeCode[PLTS_ENA_B_BIT]
    && selB == PLTS_SEL_ZPULSE && !(cmd.typeCode[PLTS_ENA_A_BIT] && plts_sel_reserved(selA))
    |=> rsp_r.cmdError == PLTS_ERR_ABS_SCALE && rsp_r.status[PLTS_ST_ERR])
    else $error("index select on serial scale not refused");
  done_flags_a: assert property (
    ce && cmdValid |=> rsp_r.status[1:0]
    == {$past(capture_done_ch_b), $past(capture_done_ch_a)})
    else $error("done flags misplaced");
  status_only_a: assert property (
    ce && cmdValid && cmd.isLatch && cmd.typeCode == PLTS_TYPE_MONITOR_ONLY
    |=> !$fell(capture_done_ch_a) && !$fell(capture_done_ch_b)
    && !$rose(armedA) && !$rose(armedB))
    else $error("status monitor changed latch state");
  mon_pos_a_a: assert property (
    ce && cmdValid && cmd.isMonitor && cmd.monitorSel == PLTS_MON_POS_A
    |=> rsp_r.monitorData == $past(capPosA))
    else $error("channel a position not returned");
  mon_pos_b_a: assert property (
    ce && cmdValid && cmd.isMonitor && cmd.monitorSel == PLTS_MON_POS_B
    |=> rsp_r.monitorData == $past(capPosB))
    else $error("channel b position not returned");
  pos_init_a: assert property (
    ce && cmdValid && cmd.isPosInit |=> !armedA && !armedB)
    else $error("position init left latch armed");
  sel_echo_a: assert property (
    ce && cmdValid |=> rsp_r.trigSelEcho == $past(cmd.trigSel)
    && rsp_r.monitorSelEcho == $past(cmd.monitorSel))
    else $error("selector echo wrong");
  // A capture in the start cycle still sets the flag
  start_arms_a: assert property (
    ce && startB && !stopB |=> armedB && (!capture_done_ch_b || $past(armedB)))
    else $error("start did not arm channel b");
  chan_a_arms_a: assert property (
    ce && startA && !stopA |=> armedA && (!capture_done_ch_a || $past(armedA)))
    else $error("start did not arm channel a");

  // Cancel must win even when the same code also starts the channel
  cancel_a_a: assert property (
    ce && latchCmd && errCode == PLTS_ERR_NONE && cmd.typeCode[PLTS_DIS_A_BIT] |=> !armedA)
    else $error("cancel left channel a armed");
  cancel_b_a: assert property (
    ce && latchCmd && errCode == PLTS_ERR_NONE && cmd.typeCode[PLTS_DIS_B_BIT] |=> !armedB)
    else $error("cancel left channel b armed");

  reserved_b_a: assert property (
    ce && latchCmd && cmd.typeCode[PLTS_ENA_B_BIT] && plts_sel_reserved(selB)
    |=> rspValid_r && rsp_r.cmdError == PLTS_ERR_RESERVED && !$rose(armedB))
    else $error("reserved selector on channel b not refused");
  err_flag_a: assert property (
    ce && cmdValid |=> rsp_r.cmdError == $past(errCode)
    && rsp_r.status[PLTS_ST_ERR] == (rsp_r.cmdError != PLTS_ERR_NONE))
    else $error("error code and error bit disagree");

  // A refused frame is dropped whole, so no channel may start or lose its flag
  refused_inert_a: assert property (
    ce && latchCmd && errCode != PLTS_ERR_NONE
    |=> !$rose(armedA) && !$rose(armedB)
    && !$fell(capture_done_ch_a) && !$fell(capture_done_ch_b))
    else $error("refused command changed latch state");

  // Other type codes on a latch frame are not latch requests at all
  nonlatch_ignored_a: assert property (
    ce && cmdValid && cmd.isLatch && !latchCmd && !cmd.isPosInit
    |=> !$rose(armedA) && !$rose(armedB) && rsp_r.cmdError == PLTS_ERR_NONE)
    else $error("non-latch type code acted on a channel");

  // Keeping the flags lets the host still read a capture taken before homing
  init_keeps_done_a: assert property (
    ce && cmdValid && cmd.isPosInit && !startA && !startB
    |=> !$fell(capture_done_ch_a) && !$fell(capture_done_ch_b))
    else $error("position init cleared a done flag");

  rsp_valid_a: assert property (
    ce |=> rspValid_r == $past(cmdValid))
    else $error("response strobe not one cycle after command");
  warn_bit_a: assert property (
    ce && cmdValid |=> rsp_r.status[PLTS_ST_WARN] == $past(warning_flag))
    else $error("warning bit not reported");

  // Monitor data is sticky: only a monitor command may replace it
  mon_hold_a: assert property (
    ce && cmdValid && !cmd.isMonitor |=> rsp_r.monitorData == $past(rsp_r.monitorData))
    else $error("monitor data changed without a monitor command");
  type_echo_a: assert property (
    ce && cmdValid |=> rsp_r.typeCodeEcho == $past(cmd.typeCode))
    else $error("type code echo wrong");

  // Fields stand until the next response
  rsp_hold_a: assert property (
    ce && !cmdValid |=> rsp_r == $past(rsp_r))
    else $error("response fields changed between responses");

  // Clock enable low must freeze every visible register
  frozen_a: assert property (
    !ce |=> $stable(armedA) && $stable(armedB) && $stable(rsp_r)
    && $stable(capture_done_ch_a) && $stable(capture_done_ch_b))
    else $error("state moved while clock enable low");

  cover_both_c: cover property (ce && startA && startB);
  cover_abs_c: cover property (ce && errCode == PLTS_ERR_ABS_SCALE);
  cover_err_c: cover property (ce && errCode == PLTS_ERR_RESERVED);
  cover_done_c: cover property (capture_done_ch_a && capture_done_ch_b);
endmodule

// >>> bench/plts_host_model.sv
// Host-side model: puts one command frame on the frame port per call.
// Assumes the bench calls send from its main sequence, one call at a time.
`timescale 1ns/1ps
module plts_host_model (
  // Frame port
  input wire logic clk,
  output logic cmdValid,
  output plts_pkg::plts_cmd_t cmd
);
  import plts_pkg::*;
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  // b selector high, a low; kind is latch, monitor, init
  task automatic send(input logic [2:0] kind, input logic [7:0] tc, input logic [7:0] sel,
                      input logic [7:0] ms);
    @(negedge clk);
    cmdValid = 1'b1;
    cmd = {kind, tc, sel, ms};
    @(negedge clk);
    cmdValid = 1'b0;
    // Released fields must not stay readable
    cmd = ~cmd;
  endtask
endmodule

// >>> bench/plts_latch_tb_top.sv
// Self-checking bench for the two-channel position latch.
// Assumes one response a cycle after each command and 3-cycle pin latency.
`timescale 1ns/1ps
module plts_latch_tb_top;
  import plts_pkg::*;
  logic clk, reset_n, ce, cmdValid, rspValid, fullClosed, serialAbsScale, warnIn;
  logic armedA, armedB, doneA, doneB, monSeen;
  logic [4:0] pins;
  logic [31:0] actualPos, monM;
  logic [31:0] posM [2];
  logic armM [2];
  logic doneM [2];
  logic [7:0] tcs [6] = '{8'h53, 8'h5c, 8'h53, 8'h55, 8'h21, 8'h43};
  plts_cmd_t cmd;
  plts_rsp_t rsp, expRsp;
  int seed = 41;
  int bad_count = 0;
  int n_tests = 0;

  plts_host_model host_u (.clk(clk), .cmdValid(cmdValid), .cmd(cmd));
  plts_latch dut_u (.clk(clk), .reset_n(reset_n), .ce(ce), .cmdValid(cmdValid), .cmd(cmd),
    .rspValid(rspValid), .rsp(rsp), .ext_trigger_a(pins[0]), .ext_trigger_b(pins[1]),
    .ext_trigger_c(pins[2]), .encoderIndex(pins[3]), .scaleIndex(pins[4]),
    .fullClosed(fullClosed), .serialAbsScale(serialAbsScale), .warning_flag(warnIn),
    .actualPos(actualPos), .armedA(armedA), .armedB(armedB), .capture_done_ch_a(doneA),
    .capture_done_ch_b(doneB));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic isRsv(input logic [3:0] s);
    return (s > 4'h3 && s < 4'h9) || s > 4'hb;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [79:0] exp, input logic [79:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkState();
    chk("latch state", {armM[0], armM[1], doneM[0], doneM[1]}, {armedA, armedB, doneA, doneB});
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic issue(input logic [2:0] kind, input logic [7:0] tc, input logic [7:0] sel,
                       input logic [7:0] ms);
    logic isLat, rsv, absErr;
    logic [15:0] err;
    logic [1:0] dnOld;
    // Byte 9 reports the flags as they stood when the frame arrived
    dnOld = {doneM[1], doneM[0]};
    isLat = kind[2] && tc[7:4] == PLTS_TYPE_LATCH_HI;
    rsv = (tc[0] && isRsv(sel[3:0])) || (tc[1] && isRsv(sel[7:4]));
    absErr = serialAbsScale && ((tc[0] && sel[3:0] == 4'h0) || (tc[1] && sel[7:4] == 4'h0));
    err = !isLat ? PLTS_ERR_NONE : rsv ? PLTS_ERR_RESERVED : absErr ? PLTS_ERR_ABS_SCALE : 16'h0;
    warnIn = 1'($random(seed));
    if (isLat && err == PLTS_ERR_NONE) begin
      for (int c = 0; c < 2; c++) begin
        if (tc[c]) begin
          armM[c] = 1'b1;
          doneM[c] = 1'b0;
        end
        // Cancel wins over a start in the same frame
        if (tc[2 + c]) begin
          armM[c] = 1'b0;
        end
      end
    end
    if (kind[0]) begin
      armM = '{1'b0, 1'b0};
    end
    if (kind[1]) begin
      monM = ms == PLTS_MON_POS_A ? posM[0] : ms == PLTS_MON_POS_B ? posM[1] : 32'h0;
    end
    host_u.send(kind, tc, sel, ms);
    expRsp = '{err, tc, {|err, warnIn, 4'h0, dnOld}, sel, ms, monM};
    chk("rspValid", 80'h1, {79'h0, rspValid});
    chk("response", expRsp, rsp);
    chkState();
  endtask

  initial begin
    logic [3:0] s4;
    logic [7:0] sel;
    logic lvl;
    int r, w;
    reset_n = 1'b0;
    ce = 1'b1;
    fullClosed = 1'b0;
    serialAbsScale = 1'b0;
    warnIn = 1'b0;
    pins = 5'h0;
    actualPos = 32'h0;
    monM = 32'h0;
    posM = '{32'h0, 32'h0};
    armM = '{1'b0, 1'b0};
    doneM = '{1'b0, 1'b0};
    waitCyc(20);
    reset_n = 1'b1;
    waitCyc(1);
    chk("reset", 80'h0, {rsp[79:1], rspValid | armedA | armedB | doneA | doneB});
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 16; s++) begin
        s4 = 4'(s);
        fullClosed = 1'($random(seed));
        serialAbsScale = s4 == 4'h0 ? c[0] : 1'($random(seed));
        lvl = s4 == 4'h0 || s4 < 4'h9;
        r = s4 == 4'h0 ? 3 + int'(fullClosed) : (s - 1) % 8;
        w = s4 == 4'h0 ? 7 - r : r;
        pins = s4 == 4'h0 ? 5'h0 : {2'b00, {3{lvl}}};
        waitCyc(5);
        sel = 8'($random(seed));
        sel[4 * c +: 4] = s4;
        issue(3'b100, 8'h50 | 8'(1 << c), sel, 8'h00);
        if (!isRsv(s4)) begin
          // Wrong edge or wrong index source first; it must not capture
          pins[w] = ~pins[w];
          waitCyc(5);
          chkState();
          actualPos = $random(seed);
          pins[w] = ~pins[w];
          pins[r] = lvl;
          if (armM[c]) begin
            doneM[c] = 1'b1;
            armM[c] = 1'b0;
            posM[c] = actualPos;
          end
          waitCyc(5);
          chkState();
        end
        actualPos = $random(seed);
        issue(3'b100, PLTS_TYPE_MONITOR_ONLY, sel, 8'h00);
        if (doneM[c]) begin
          issue(3'b010, 8'h00, sel, 8'h09 + 8'(c));
        end
      end
      $display("test channel %0d selectors finished", c);
    end
    pins = 5'h0;
    serialAbsScale = 1'b0;
    waitCyc(5);
    foreach (tcs[i]) issue(i == 4 ? 3'b001 : 3'b100, tcs[i], 8'h21, 8'h00);
    pins = 5'h07;
    waitCyc(5);
    chkState();
    issue(3'b010, 8'h00, 8'h21, 8'h0b);
    $display("test cancel and init finished");
    // A pin edge seen while the clock enable is low must wait for it
    pins = 5'h0;
    waitCyc(5);
    issue(3'b100, 8'h51, 8'h21, 8'h00);
    actualPos = $random(seed);
    ce = 1'b0;
    pins[0] = 1'b1;
    waitCyc(5);
    chkState();
    ce = 1'b1;
    doneM[0] = 1'b1;
    armM[0] = 1'b0;
    posM[0] = actualPos;
    waitCyc(5);
    chkState();
    issue(3'b010, 8'h00, 8'h21, PLTS_MON_POS_A);
    $display("test clock enable finished");
    summarize();
  end

  initial begin
    // Roughly 32 passes of under 60 cycles each, with wide margin
    #(20 * 20000);
    bad_count++;
    $display("BAD watchdog expected finish seen timeout");
    summarize();
  end
endmodule
